/* design/cag_params.svh */
// Purpose: shared constants for the coprocessor attach glue
// Assumes: included by bare name
// Notes: offsets are byte addresses on the apb side
`ifndef CAG_PARAMS_SVH
`define CAG_PARAMS_SVH

// ----------------------------------------
// instruction fields
// ----------------------------------------
`define CAG_BIT_CPCLASS 27
`define CAG_BIT_LOAD 20
`define CAG_CPNUM_HI 11
`define CAG_CPNUM_LO 8
`define CAG_DEBUG_CP 4'he
`define CAG_NUM_CP 2
`define CAG_CP_ID0 4'h5
`define CAG_CP_ID1 4'h6

// ----------------------------------------
// apb register map
// ----------------------------------------
`define CAG_OFF_CTRL 12'h000
`define CAG_OFF_BUSY 12'h004
`define CAG_OFF_STAT 12'h008
`define CAG_OFF_REG0 12'h00c
`define CAG_OFF_REG1 12'h010
`define CAG_CTRL_ATTACH 0
`define CAG_CTRL_PRIV 1
`define CAG_CTRL_RST 2'h0
`define CAG_BUSY_RST 8'h00
`define CAG_CNT_ONE 16'h0001

`endif

/* design/cag_pkg.sv */
// Purpose: types shared by both ends
// Assumes: cag_params.svh holds the numbers
// Notes: none
package cag_pkg;
    typedef enum logic [1:0] {
        CAG_IDLE = 2'b00,
        CAG_FETCH = 2'b01,
        CAG_DECODE = 2'b10,
        CAG_EXEC = 2'b11
    } cag_core_state_type;
endpackage

/* design/cag_link_if.sv */
// Purpose: handshake and data pins between core and coprocessor side
// Assumes: one clock, pclk
// Notes: no two-way pins; the unidirectional bus style is used
`timescale 1ns/100ps
interface cag_link_if;
    logic [31:0] instr;
    logic [31:0] core_wdata;
    logic [31:0] coproc_rdata;
    logic instr_fetch_n;
    logic privileged_fetch;
    logic compressed_state;
    logic coproc_commit_n;
    logic coproc_absent_in;
    logic coproc_wait_in;
    logic mem_request_n;
    logic sequential_cycle;
    logic write_not_read;

    modport core (
        output instr, core_wdata, instr_fetch_n, privileged_fetch, compressed_state,
        output coproc_commit_n, mem_request_n, sequential_cycle, write_not_read,
        input coproc_rdata, coproc_absent_in, coproc_wait_in
    );
    modport coproc (
        input instr, core_wdata, instr_fetch_n, privileged_fetch, compressed_state,
        input coproc_commit_n, mem_request_n, sequential_cycle, write_not_read,
        output coproc_rdata, coproc_absent_in, coproc_wait_in
    );
endinterface

/* design/cag_coproc_end.sv */
// Purpose: coprocessor side: two coprocessors, handshake combine and bus glue
// Assumes: core end drives the link on pclk; software uses apb
// Notes: responses are registered, so they lag the decode stage by one cycle
//
// Notes on behaviour
// - full 32-bit instruction, write and read paths
// - load and store data paths are both always present
// - core-out select on falling edge, read cycles
// - coproc-data select on falling edge, write cycles
// - commit strobe reaches every coprocessor
// - absent and wait outputs ANDed toward core
// - read data multiplexed from responding coprocessor
// - no coprocessor attached: absent and wait high
// - unaccepted instruction takes undefined trap
// - internal debug coprocessor stays usable
// - commit, fetch, state outputs always driven
// - undefined instructions answered absent by all
// - bit 27 low means undefined, refuse
// - compressed state: ignore bus, answer absent
// - privilege output low user, high privileged
// - privilege captured with fetch, used decoding
// - user access to privileged function: absent
// - response encoding accept, wait, absent
// - execute only after commit seen low
// - commit high during wait abandons instruction
`timescale 1ns/100ps
`include "cag_params.svh"
module cag_coproc_end
    import cag_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    cag_link_if.coproc link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic core_out_drive_sel,
    output logic coproc_data_sel
);
    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic cp_claims(input logic [31:0] ins, input logic [3:0] id,
                                       input logic priv, input logic priv_only,
                                       input logic comp);
        logic ok;
        ok = 1'b1;
        if (comp) begin
            ok = 1'b0;
        end
        if (!ins[`CAG_BIT_CPCLASS]) begin
            ok = 1'b0;
        end
        if (ins[`CAG_CPNUM_HI:`CAG_CPNUM_LO] != id) begin
            ok = 1'b0;
        end
        if (priv_only && !priv) begin
            ok = 1'b0;
        end
        return ok;
    endfunction

    localparam logic [3:0] CP_IDS [`CAG_NUM_CP] = '{`CAG_CP_ID0, `CAG_CP_ID1};

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [1:0] ctrl_q;
    logic [7:0] busy_cycles_q;
    logic [15:0] exec_cnt_q;
    logic [31:0] dec_instr_q;
    logic dec_priv_q;
    logic dec_valid_q;
    logic [31:0] cp_reg_q [`CAG_NUM_CP];
    logic [7:0] wait_cnt_q [`CAG_NUM_CP];
    logic absent_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic core_out_drive_sel_q;
    logic coproc_data_sel_q;

    wire logic attach_en = ctrl_q[`CAG_CTRL_ATTACH];
    wire logic priv_only = ctrl_q[`CAG_CTRL_PRIV];
    wire logic fetch_now = !link.instr_fetch_n;
    wire logic committed = !link.coproc_commit_n;
    logic [`CAG_NUM_CP-1:0] claim;
    logic [`CAG_NUM_CP-1:0] unit_absent;
    logic [`CAG_NUM_CP-1:0] unit_wait;
    logic [`CAG_NUM_CP-1:0] unit_exec;

    for (genvar g = 0; g < `CAG_NUM_CP; g++) begin : g_unit
        assign claim[g] = dec_valid_q && cp_claims(dec_instr_q, CP_IDS[g], dec_priv_q,
                                                   priv_only, link.compressed_state);
        assign unit_absent[g] = !claim[g];
        assign unit_wait[g] = !claim[g] || (wait_cnt_q[g] != 8'h00);
        assign unit_exec[g] = claim[g] && (wait_cnt_q[g] == 8'h00) && committed;
    end

    wire logic all_absent = attach_en ? &unit_absent : 1'b1;
    wire logic all_wait = attach_en ? &unit_wait : 1'b1;
    wire logic [31:0] mux_rdata = claim[1] ? cp_reg_q[1] : cp_reg_q[0];
    wire logic any_exec = |unit_exec;

    // ----------------------------------------
    // decode stage and coprocessor units
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_instr_q <= 32'h0000_0000;
            dec_priv_q <= 1'b0;
            dec_valid_q <= 1'b0;
        end else if (fetch_now) begin
            dec_instr_q <= link.instr;
            dec_priv_q <= link.privileged_fetch;
            dec_valid_q <= 1'b1;
        end else if (any_exec) begin
            dec_valid_q <= 1'b0;
        end
    end

    // unit data registers cp_reg_q change only on execution, so an abandoned wait leaves nothing behind
    for (genvar u = 0; u < `CAG_NUM_CP; u++) begin : g_regs
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cp_reg_q[u] <= 32'h0000_0000;
                wait_cnt_q[u] <= 8'h00;
            end else begin
                if (fetch_now) begin
                    wait_cnt_q[u] <= busy_cycles_q;
                end else if (wait_cnt_q[u] != 8'h00) begin
                    wait_cnt_q[u] <= wait_cnt_q[u] - 8'h01;
                end
                if (unit_exec[u] && !dec_instr_q[`CAG_BIT_LOAD]) begin
                    cp_reg_q[u] <= link.core_wdata;
                end
            end
        end
    end

    // ----------------------------------------
    // handshake toward the core
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            absent_q <= 1'b1;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            exec_cnt_q <= 16'h0000;
        end else begin
            absent_q <= all_absent;
            wait_q <= all_wait;
            rdata_q <= mux_rdata;
            if (any_exec) begin
                exec_cnt_q <= exec_cnt_q + `CAG_CNT_ONE;
            end
        end
    end

    assign link.coproc_absent_in = absent_q;
    assign link.coproc_wait_in = wait_q;
    assign link.coproc_rdata = rdata_q;

    // ----------------------------------------
    // unidirectional bus selects
    // ----------------------------------------
    wire logic cp_cycle = link.mem_request_n && link.sequential_cycle;

    always_ff @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_out_drive_sel_q <= 1'b0;
            coproc_data_sel_q <= 1'b0;
        end else begin
            core_out_drive_sel_q <= cp_cycle && !link.write_not_read;
            coproc_data_sel_q <= cp_cycle && link.write_not_read;
        end
    end

    assign core_out_drive_sel = core_out_drive_sel_q;
    assign coproc_data_sel = coproc_data_sel_q;

    // ----------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------
    wire logic setup = psel && !penable;
    wire logic wr_en = psel && penable && pwrite;
    wire logic hit_ctrl = paddr == `CAG_OFF_CTRL;
    wire logic hit_busy = paddr == `CAG_OFF_BUSY;
    wire logic hit_stat = paddr == `CAG_OFF_STAT;
    wire logic hit_reg0 = paddr == `CAG_OFF_REG0;
    wire logic hit_reg1 = paddr == `CAG_OFF_REG1;
    wire logic hit_any = hit_ctrl | hit_busy | hit_stat | hit_reg0 | hit_reg1;
    wire logic [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
                               hit_busy ? {24'h0, busy_cycles_q} :
                               hit_stat ? {14'h0, absent_q, wait_q, exec_cnt_q} :
                               hit_reg0 ? cp_reg_q[0] :
                               hit_reg1 ? cp_reg_q[1] : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CAG_CTRL_RST;
            busy_cycles_q <= `CAG_BUSY_RST;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            if (setup) begin
                prdata_q <= rd_mux;
                pslverr_q <= !hit_any;
            end
            if (wr_en && hit_ctrl) begin
                ctrl_q <= pwdata[1:0];
            end
            if (wr_en && hit_busy) begin
                busy_cycles_q <= pwdata[7:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pready = 1'b1;
endmodule // cag_coproc_end

/* design/cag_core_end.sv */
// Purpose: core side of the coprocessor handshake
// Assumes: one instruction at a time from the user side
// Notes: the internal debug coprocessor number is answered here, not on the link
`timescale 1ns/100ps
`include "cag_params.svh"
module cag_core_end
    import cag_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    cag_link_if.core link,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] issue_wdata,
    input wire logic issue_priv,
    input wire logic issue_cond_pass,
    input wire logic compressed_mode,
    input wire logic irq,
    output logic issue_ready,
    output logic done_accept,
    output logic done_undef,
    output logic done_abandon,
    output logic [31:0] read_data
);
    cag_core_state_type state_q;
    logic [31:0] instr_q;
    logic [31:0] wdata_q;
    logic priv_q;
    logic cond_q;
    logic fetch_n_q;
    logic commit_n_q;
    logic mreq_n_q;
    logic seq_q;
    logic wnr_q;
    logic comp_q;
    logic acc_q;
    logic undef_q;
    logic aband_q;
    logic [31:0] rdata_q;
    logic ready_q;

    wire logic is_debug = instr_q[`CAG_CPNUM_HI:`CAG_CPNUM_LO] == `CAG_DEBUG_CP;
    wire logic resp_absent = link.coproc_absent_in && link.coproc_wait_in;
    wire logic resp_accept = !link.coproc_absent_in && !link.coproc_wait_in;
    wire logic internal_ok = is_debug && instr_q[`CAG_BIT_CPCLASS] && !comp_q;
    // every way out of execute, so ready can be a flop
    wire logic exec_done = !cond_q || internal_ok || resp_absent || resp_accept || irq;

    // ----------------------------------------
    // instruction sequence
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= CAG_IDLE;
            ready_q <= 1'b1;
            instr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            priv_q <= 1'b0;
            cond_q <= 1'b0;
            fetch_n_q <= 1'b1;
            commit_n_q <= 1'b1;
            mreq_n_q <= 1'b0;
            seq_q <= 1'b0;
            wnr_q <= 1'b0;
            acc_q <= 1'b0;
            undef_q <= 1'b0;
            aband_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            acc_q <= 1'b0;
            undef_q <= 1'b0;
            aband_q <= 1'b0;
            commit_n_q <= 1'b1;
            mreq_n_q <= 1'b0;
            seq_q <= 1'b0;
            case (state_q)
                CAG_IDLE: begin
                    if (issue_valid) begin
                        ready_q <= 1'b0;
                        instr_q <= issue_instr;
                        wdata_q <= issue_wdata;
                        priv_q <= issue_priv;
                        cond_q <= issue_cond_pass;
                        fetch_n_q <= 1'b0;
                        state_q <= CAG_FETCH;
                    end
                end
                CAG_FETCH: begin
                    fetch_n_q <= 1'b1;
                    state_q <= CAG_DECODE;
                end
                // one spare cycle lets the registered response settle
                CAG_DECODE: begin
                    state_q <= CAG_EXEC;
                end
                CAG_EXEC: begin
                    if (exec_done) begin
                        ready_q <= 1'b1;
                    end
                    if (!cond_q) begin
                        state_q <= CAG_IDLE;
                    end else if (internal_ok) begin
                        acc_q <= 1'b1;
                        state_q <= CAG_IDLE;
                    end else if (resp_absent) begin
                        undef_q <= 1'b1;
                        state_q <= CAG_IDLE;
                    end else if (resp_accept) begin
                        commit_n_q <= 1'b0;
                        mreq_n_q <= 1'b1;
                        seq_q <= 1'b1;
                        wnr_q <= !instr_q[`CAG_BIT_LOAD];
                        rdata_q <= link.coproc_rdata;
                        acc_q <= 1'b1;
                        state_q <= CAG_IDLE;
                    end else if (irq) begin
                        aband_q <= 1'b1;
                        state_q <= CAG_IDLE;
                    end
                end
                default: begin
                    ready_q <= 1'b1;
                    state_q <= CAG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_q <= 1'b0;
        end else begin
            comp_q <= compressed_mode;
        end
    end

    assign link.instr = instr_q;
    assign link.core_wdata = wdata_q;
    assign link.instr_fetch_n = fetch_n_q;
    assign link.privileged_fetch = priv_q;
    assign link.compressed_state = comp_q;
    assign link.coproc_commit_n = commit_n_q;
    assign link.mem_request_n = mreq_n_q;
    assign link.sequential_cycle = seq_q;
    assign link.write_not_read = wnr_q;
    assign issue_ready = ready_q;
    assign done_accept = acc_q;
    assign done_undef = undef_q;
    assign done_abandon = aband_q;
    assign read_data = rdata_q;
endmodule // cag_core_end

/* tb/cag_link_assertions.sv */
// Purpose: link handshake and bus select checks
// Assumes: one clock, pclk; selects flop on falling pclk
// Notes: sampled at rising pclk, where the link flops are settled
`timescale 1ns/100ps
`include "cag_params.svh"
module cag_link_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] instr,
    input wire logic instr_fetch_n,
    input wire logic compressed_state,
    input wire logic coproc_commit_n,
    input wire logic coproc_absent_in,
    input wire logic coproc_wait_in,
    input wire logic mem_request_n,
    input wire logic sequential_cycle,
    input wire logic write_not_read,
    input wire logic core_out_drive_sel,
    input wire logic coproc_data_sel
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic rd_cyc = mem_request_n && sequential_cycle && !write_not_read;
    wire logic wr_cyc = mem_request_n && sequential_cycle && write_not_read;
    wire logic both_hi = coproc_absent_in && coproc_wait_in;
    a_sel_read: assert property (core_out_drive_sel == rd_cyc)
        else $error("core out select wrong");
    a_sel_write: assert property (coproc_data_sel == wr_cyc)
        else $error("coproc data select wrong");
    a_sel_in_reset: assert property (disable iff (1'b0)
        !presetn |-> !core_out_drive_sel && !coproc_data_sel)
        else $error("select high during reset");
    a_undef_absent: assert property (
        !instr_fetch_n && !instr[`CAG_BIT_CPCLASS] |-> ##2 both_hi)
        else $error("undefined instruction not refused");
    a_comp_absent: assert property (
        !instr_fetch_n && compressed_state |-> ##2 both_hi)
        else $error("compressed state not refused");
    a_no_invalid: assert property (!(coproc_absent_in && !coproc_wait_in))
        else $error("invalid response code");
    a_commit_pulse: assert property (
        !coproc_commit_n |-> mem_request_n && sequential_cycle ##1 coproc_commit_n)
        else $error("commit pulse malformed");
    a_commit_gap: assert property (!instr_fetch_n |-> coproc_commit_n[*3])
        else $error("commit too soon after fetch");
    a_commit_ok: assert property (
        !coproc_commit_n && instr[`CAG_CPNUM_HI:`CAG_CPNUM_LO] != `CAG_DEBUG_CP
        |-> $past(!coproc_absent_in && !coproc_wait_in))
        else $error("commit without accept");
    c_read_commit: cover property (!coproc_commit_n && !write_not_read);
    c_write_commit: cover property (!coproc_commit_n && write_not_read);
    c_busy_wait: cover property (!coproc_absent_in && coproc_wait_in);
endmodule // cag_link_assertions

/* tb/coproc_attach_glue_tb.sv */
// Purpose: self-checking bench for both ends of the link
// Assumes: pready may stall; expectations from bench model only
// Notes: unit registers modelled, so reads check the data paths
`timescale 1ns/100ps
`include "cag_params.svh"
module coproc_attach_glue_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic issue_valid = 1'b0;
    logic [31:0] issue_instr = 32'h0;
    logic [31:0] issue_wdata = 32'h0;
    logic issue_priv = 1'b0;
    logic issue_cond_pass = 1'b1;
    logic compressed_mode = 1'b0;
    logic irq = 1'b0;
    logic issue_ready, done_accept, done_undef, done_abandon, pready, pslverr;
    logic core_out_drive_sel, coproc_data_sel;
    logic [31:0] read_data, prdata;
    logic [31:0] regm [2] = '{32'h0, 32'h0};
    logic attach = 1'b0;
    logic ponly = 1'b0;
    int num_errors = 0;
    int cmp_count = 0;
    int n_exec = 0;
    int seed = 32'h845bdaff;
    always #50 pclk = ~pclk;
    cag_link_if link ();
    cag_core_end cag_core_end_inst (.pclk(pclk), .presetn(presetn), .link(link),
        .issue_valid(issue_valid), .issue_instr(issue_instr), .issue_wdata(issue_wdata),
        .issue_priv(issue_priv), .issue_cond_pass(issue_cond_pass),
        .compressed_mode(compressed_mode), .irq(irq), .issue_ready(issue_ready),
        .done_accept(done_accept), .done_undef(done_undef), .done_abandon(done_abandon),
        .read_data(read_data));
    cag_coproc_end cag_coproc_end_inst (.pclk(pclk), .presetn(presetn), .link(link),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .core_out_drive_sel(core_out_drive_sel), .coproc_data_sel(coproc_data_sel));
    cag_link_assertions cag_link_assertions_inst (.pclk(pclk), .presetn(presetn),
        .instr(link.instr), .instr_fetch_n(link.instr_fetch_n),
        .compressed_state(link.compressed_state), .coproc_commit_n(link.coproc_commit_n),
        .coproc_absent_in(link.coproc_absent_in), .coproc_wait_in(link.coproc_wait_in),
        .mem_request_n(link.mem_request_n), .sequential_cycle(link.sequential_cycle),
        .write_not_read(link.write_not_read), .core_out_drive_sel(core_out_drive_sel),
        .coproc_data_sel(coproc_data_sel));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("mismatches %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task tmo;
        num_errors++;
        end_of_test();
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 16)
            tmo();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    function automatic logic [31:0] mk(logic cls, logic [3:0] cp, logic ld);
        logic [31:0] r;
        r = $random(seed);
        r[`CAG_BIT_CPCLASS] = cls;
        r[`CAG_CPNUM_HI:`CAG_CPNUM_LO] = cp;
        r[`CAG_BIT_LOAD] = ld;
        return r;
    endfunction
    // 1 accept, 2 undefined trap, 3 abandon, 0 nothing
    function automatic int expect_of(logic [31:0] ins, logic pv);
        logic [3:0] cp;
        cp = ins[`CAG_CPNUM_HI:`CAG_CPNUM_LO];
        if (!ins[`CAG_BIT_CPCLASS])
            return 2;
        if (cp == `CAG_DEBUG_CP)
            return 1;
        if (attach && !compressed_mode && (cp == `CAG_CP_ID0 || cp == `CAG_CP_ID1)
            && (pv || !ponly))
            return 1;
        return 2;
    endfunction
    task iss(input logic [31:0] ins, input logic pv, input logic cnd, input int exp);
        int i;
        int got;
        logic [31:0] wd;
        logic [3:0] cp;
        wd = $random(seed);
        cp = ins[`CAG_CPNUM_HI:`CAG_CPNUM_LO];
        for (i = 0; i < 50 && issue_ready !== 1'b1; i++)
            @(negedge pclk);
        if (i == 50)
            tmo();
        @(posedge pclk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        issue_wdata <= wd;
        issue_priv <= pv;
        issue_cond_pass <= cnd;
        @(posedge pclk);
        issue_valid <= 1'b0;
        got = 0;
        for (i = 0; i < 40 && got == 0; i++) begin
            @(negedge pclk);
            got = done_accept === 1'b1 ? 1 : done_undef === 1'b1 ? 2 :
                  done_abandon === 1'b1 ? 3 : 0;
        end
        if (got == 0 && exp != 0)
            tmo();
        chk(got, exp);
        if (got == 1 && cp != `CAG_DEBUG_CP) begin
            n_exec++;
            if (!ins[`CAG_BIT_LOAD])
                regm[cp - `CAG_CP_ID0] = wd;
            else
                chk(read_data, regm[cp - `CAG_CP_ID0]);
        end
        // return on a rising edge so callers change inputs just after it
        @(posedge pclk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] ins;
        logic [31:0] q;
        logic e;
        logic pv;
        logic [3:0] cps [4];
        cps = '{4'h5, 4'h6, 4'h7, 4'he};
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        chk({28'h0, core_out_drive_sel, coproc_data_sel, link.coproc_absent_in,
             link.coproc_wait_in}, 32'h3);
        presetn <= 1'b1;
        rd(`CAG_OFF_CTRL, 32'h0, 1'b0);
        rd(`CAG_OFF_BUSY, 32'h0, 1'b0);
        rd(12'h014, 32'h0, 1'b1);
        iss(mk(1'b1, 4'h5, 1'b0), 1'b1, 1'b1, 2);
        iss(mk(1'b1, 4'he, 1'b0), 1'b1, 1'b1, 1);
        wr(`CAG_OFF_CTRL, 32'h1);
        attach = 1'b1;
        iss(mk(1'b1, 4'h5, 1'b0), 1'b0, 1'b1, 1);
        iss(mk(1'b1, 4'h6, 1'b0), 1'b0, 1'b1, 1);
        repeat (24) begin
            ins = mk(($random(seed) & 3) != 0, cps[$random(seed) & 3], $random(seed));
            pv = $random(seed);
            iss(ins, pv, 1'b1, expect_of(ins, pv));
        end
        rd(`CAG_OFF_REG0, regm[0], 1'b0);
        rd(`CAG_OFF_REG1, regm[1], 1'b0);
        wr(`CAG_OFF_CTRL, 32'h3);
        ponly = 1'b1;
        iss(mk(1'b1, 4'h5, 1'b1), 1'b0, 1'b1, 2);
        iss(mk(1'b1, 4'h6, 1'b1), 1'b1, 1'b1, 1);
        compressed_mode <= 1'b1;
        iss(mk(1'b1, 4'h6, 1'b0), 1'b1, 1'b1, 2);
        compressed_mode <= 1'b0;
        iss(mk(1'b1, 4'h5, 1'b0), 1'b1, 1'b0, 0);
        wr(`CAG_OFF_BUSY, 32'h3);
        iss(mk(1'b1, 4'h6, 1'b1), 1'b1, 1'b1, 1);
        wr(`CAG_OFF_BUSY, 32'h8);
        irq <= 1'b1;
        iss(mk(1'b1, 4'h5, 1'b0), 1'b1, 1'b1, 3);
        irq <= 1'b0;
        rd(`CAG_OFF_REG0, regm[0], 1'b0);
        apb(1'b0, `CAG_OFF_STAT, 32'h0, q, e);
        chk(q & 32'hffff, n_exec);
        end_of_test();
    end
endmodule // coproc_attach_glue_tb
